/* File: shared/aldr_pkg.sv */
/*
 * Shared constants of the ambient light readout: bus addresses, register map,
 * field positions, reset values and timing counts.
 * Assumes a single 250 MHz system clock at both ends.
 */
package aldr_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_HZ = 250_000_000;
	localparam int CONV_TIME_US = 300;
	localparam int FRAME_TIME_MS = 100;
	localparam int CONV_CYCLES = CONV_TIME_US * (CLK_HZ / 1_000_000);
	localparam int FRAME_CYCLES = FRAME_TIME_MS * (CLK_HZ / 1_000);
	localparam int I2C_RATE_HZ = 100_000;
	localparam int QUARTER_CYCLES = CLK_HZ / (I2C_RATE_HZ * 4);

	// ==========================================================
	// serial bus addressing
	localparam logic [6:0] SLAVE_ADDR = 7'h13;
	localparam logic [7:0] ADDR_BYTE_WRITE = 8'h26;
	localparam logic [7:0] ADDR_BYTE_READ = 8'h27;

	// ==========================================================
	// sensor register map
	localparam logic [7:0] REG_COMMAND = 8'h80;
	localparam logic [7:0] REG_AMBIENT_PARAM = 8'h84;
	localparam logic [7:0] REG_AMBIENT_RESULT_HIGH = 8'h85;
	localparam logic [7:0] REG_AMBIENT_RESULT_LOW = 8'h86;
	localparam logic [7:0] REG_MODULATOR_TIMING = 8'h8f;
	localparam logic [7:0] REG_AMBIENT_INFRARED_LEVEL = 8'h90;
	localparam int CMD_PERIODIC_BIT = 2;
	localparam int CMD_ON_DEMAND_BIT = 4;
	localparam int CMD_READY_BIT = 6;
	localparam int PARAM_CONTINUOUS_BIT = 7;
	localparam int PARAM_AVG_LSB = 0;
	localparam logic [7:0] COMMAND_RESET = 8'h00;
	localparam logic [7:0] AMBIENT_PARAM_RESET = 8'h00;
	localparam logic [7:0] MODULATOR_TIMING_RESET = 8'h01;

	// ==========================================================
	// controller command port
	localparam logic [7:0] HOST_REG_CMD = 8'h00;
	localparam logic [7:0] HOST_REG_STATUS = 8'h04;
	localparam logic [7:0] HOST_REG_DATA = 8'h08;
	localparam int HCMD_READ_BIT = 16;
	localparam int HCMD_RSTART_BIT = 17;
	localparam int HCMD_COUNT_LSB = 18;
endpackage : aldr_pkg

/* File: shared/aldr_i2c_if.sv */
/*
 * Two-wire serial link between the controller and the sensor end.
 * Data line is open drain with a pull-up; clock is driven by the controller only.
 */
`timescale 1ns/10ps
interface aldr_i2c_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic sda;

	// wired-and of the data line with pull-up
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

	modport master (output scl, output host_sda_o, output host_sda_oe_n, input sda);
	modport sensor (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : aldr_i2c_if

/* File: rtl/aldr_sensor.sv */
/*
 * Sensor end: serial register slave plus ambient light conversion sequencer.
 * Assumes scl and sda are synchronous to clk and far slower than it.
 */
// Functional notes
// - master writes pointer, then reads data
// - stop or repeated start both accepted
// - pointer increments after every byte read
// - address bytes 26h write, 27h read
// - result high at 85h, low 86h
// - standard mode uses fixed 100 ms frame
// - each conversion takes about 300 us
// - average up to 128 conversions reported
// - standard mode result published at frame end
// - continuous mode conversions run back to back
// - idle without demand, only interface active
// - software programs modulator timing to 1
// - host leaves register 90h alone; the bench writes ffh to it
`timescale 1ns/10ps
module aldr_sensor #(
	parameter int CONV_CYC = aldr_pkg::CONV_CYCLES,
	parameter int FRAME_CYC = aldr_pkg::FRAME_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	aldr_i2c_if.sensor bus,
	input wire logic [15:0] light_sample,
	output logic standby,
	output logic [15:0] ambient_result
);
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WR, S_RD} aldr_slave_type;
	typedef enum logic [1:0] {M_IDLE, M_CONV, M_HOLD} aldr_meas_type;
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		aldr_slave_type sst;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [7:0] txb;
		logic nack;
		logic drive_low;
		logic [7:0] ptr;
		logic [7:0] cmd;
		logic [7:0] param;
		logic [7:0] modt;
		logic [15:0] result;
		aldr_meas_type mst;
		logic [31:0] frame_cnt;
		logic [31:0] conv_cnt;
		logic [7:0] n_done;
		logic [22:0] sum;
	} aldr_sensor_state_type;

	localparam int CMDW = aldr_pkg::CMD_READY_BIT;

	aldr_sensor_state_type s;
	aldr_sensor_state_type next_s;

	// ==========================================================
	// register read view
	function automatic logic [7:0] reg_read(input logic [7:0] a, input aldr_sensor_state_type st);
		logic [7:0] v;
		v = 8'h00;
		if (a == aldr_pkg::REG_COMMAND) begin
			v = st.cmd;
		end else if (a == aldr_pkg::REG_AMBIENT_PARAM) begin
			v = st.param;
		end else if (a == aldr_pkg::REG_AMBIENT_RESULT_HIGH) begin
			v = st.result[15:8];
		end else if (a == aldr_pkg::REG_AMBIENT_RESULT_LOW) begin
			v = st.result[7:0];
		end else if (a == aldr_pkg::REG_MODULATOR_TIMING) begin
			v = st.modt;
		end
		return v;
	endfunction : reg_read

	// ==========================================================
	// next state
	always_comb begin
		logic rise;
		logic fall;
		logic start_c;
		logic stop_c;
		logic pub;
		logic [2:0] avg_code;
		logic [7:0] avg_n;
		logic [7:0] rv;
		logic [22:0] fsum;
		logic cmd_wr;
		rise = bus.scl & ~s.scl_q;
		fall = ~bus.scl & s.scl_q;
		start_c = bus.scl & s.scl_q & s.sda_q & ~bus.sda;
		stop_c = bus.scl & s.scl_q & ~s.sda_q & bus.sda;
		pub = 1'b0;
		avg_code = s.param[aldr_pkg::PARAM_AVG_LSB +: 3];
		avg_n = 8'h01 << avg_code;
		rv = reg_read(s.ptr, s);
		fsum = s.sum;
		cmd_wr = 1'b0;
		next_s = s;
		next_s.scl_q = bus.scl;
		next_s.sda_q = bus.sda;

		if (start_c) begin
			next_s.sst = S_ADDR;
			next_s.bitc = 4'h0;
			next_s.drive_low = 1'b0;
		end else if (stop_c) begin
			next_s.sst = S_IDLE;
			next_s.drive_low = 1'b0;
		end else if (s.sst != S_IDLE) begin
			if (rise) begin
				if (s.bitc < 4'h8) begin
					next_s.sh = {s.sh[6:0], bus.sda};
				end
				if (s.bitc == 4'h8 && s.sst == S_RD) begin
					next_s.nack = bus.sda;
					next_s.ptr = s.ptr + 8'h01;
				end
				next_s.bitc = s.bitc + 4'h1;
			end else if (fall) begin
				if (s.bitc == 4'h8) begin
					if (s.sst == S_RD) begin
						next_s.drive_low = 1'b0;
					end else if (s.sst == S_ADDR && s.sh[7:1] != aldr_pkg::SLAVE_ADDR) begin
						next_s.sst = S_IDLE;
					end else begin
						next_s.drive_low = 1'b1;
					end
				end else if (s.bitc == 4'h9) begin
					next_s.drive_low = 1'b0;
					next_s.bitc = 4'h0;
					case (s.sst)
						S_ADDR: begin
							next_s.nack = 1'b0;
							next_s.sst = s.sh[0] ? S_RD : S_PTR;
						end
						S_PTR: begin
							next_s.ptr = s.sh;
							next_s.sst = S_WR;
						end
						S_WR: begin
							if (s.ptr == aldr_pkg::REG_COMMAND) begin
								next_s.cmd[CMDW-1:0] = s.sh[CMDW-1:0];
								cmd_wr = 1'b1;
							end else if (s.ptr == aldr_pkg::REG_AMBIENT_PARAM) begin
								next_s.param = s.sh;
							end else if (s.ptr == aldr_pkg::REG_MODULATOR_TIMING) begin
								next_s.modt = s.sh;
							end
							next_s.ptr = s.ptr + 8'h01;
						end
						default: begin
							if (s.nack) begin
								next_s.sst = S_IDLE;
							end
						end
					endcase
					if ((s.sst == S_ADDR && s.sh[0]) || (s.sst == S_RD && !s.nack)) begin
						next_s.txb = rv;
						next_s.drive_low = ~rv[7];
						if (s.ptr == aldr_pkg::REG_AMBIENT_RESULT_HIGH) begin
							next_s.cmd[aldr_pkg::CMD_READY_BIT] = 1'b0;
						end
					end
				end else if (s.sst == S_RD) begin
					next_s.drive_low = ~s.txb[3'(4'h7 - s.bitc)];
				end
			end
		end

		// ==========================================================
		// conversion sequencer
		case (s.mst)
			M_IDLE: begin
				if (s.cmd[aldr_pkg::CMD_ON_DEMAND_BIT] || s.cmd[aldr_pkg::CMD_PERIODIC_BIT]) begin
					next_s.mst = M_CONV;
					next_s.frame_cnt = 32'h0;
					next_s.conv_cnt = 32'h0;
					next_s.n_done = 8'h00;
					next_s.sum = 23'h0;
				end
			end
			M_CONV: begin
				next_s.frame_cnt = s.frame_cnt + 32'h1;
				next_s.conv_cnt = s.conv_cnt + 32'h1;
				if (s.conv_cnt == 32'(CONV_CYC - 1)) begin
					next_s.conv_cnt = 32'h0;
					fsum = s.sum + {7'h00, light_sample};
					next_s.sum = fsum;
					next_s.n_done = s.n_done + 8'h01;
					if (s.n_done + 8'h01 == avg_n) begin
						if (s.param[aldr_pkg::PARAM_CONTINUOUS_BIT]) begin
							pub = 1'b1;
						end else begin
							next_s.mst = M_HOLD;
						end
					end
				end
			end
			default: begin
				next_s.frame_cnt = s.frame_cnt + 32'h1;
				if (s.frame_cnt == 32'(FRAME_CYC - 1)) begin
					pub = 1'b1;
				end
			end
		endcase
		if (pub) begin
			next_s.result = 16'(fsum >> avg_code);
			next_s.cmd[aldr_pkg::CMD_READY_BIT] = 1'b1;
			// software write in the same cycle wins over the clear
			if (!cmd_wr) begin
				next_s.cmd[aldr_pkg::CMD_ON_DEMAND_BIT] = 1'b0;
			end
			next_s.mst = M_IDLE;
			if (s.cmd[aldr_pkg::CMD_PERIODIC_BIT]) begin
				next_s.mst = M_CONV;
				next_s.frame_cnt = 32'h0;
				next_s.conv_cnt = 32'h0;
				next_s.n_done = 8'h00;
				next_s.sum = 23'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.cmd <= aldr_pkg::COMMAND_RESET;
			s.param <= aldr_pkg::AMBIENT_PARAM_RESET;
			s.modt <= aldr_pkg::MODULATOR_TIMING_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = ~s.drive_low;
	assign standby = (s.mst == M_IDLE);
	assign ambient_result = s.result;
endmodule : aldr_sensor

/* File: rtl/aldr_host.sv */
/*
 * Controller end: runs pointer-write then read sequences on the serial link
 * from commands given over a plain register port.
 * Assumes sda is synchronous to clk; scl is made here by a divider.
 */
`timescale 1ns/10ps
module aldr_host #(
	parameter int QUARTER = aldr_pkg::QUARTER_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	aldr_i2c_if.master bus,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} aldr_host_st_type;
	typedef struct packed {
		aldr_host_st_type st;
		logic [1:0] q;
		logic [15:0] div;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [2:0] step;
		logic scl;
		logic sda_rel;
		logic [19:0] cmd;
		logic [2:0] left;
		logic busy;
		logic nack;
		logic [31:0] data;
		logic [31:0] rdata;
	} aldr_host_state_type;

	localparam logic [2:0] ST_WADDR = 3'h0;
	localparam logic [2:0] ST_PTR = 3'h1;
	localparam logic [2:0] ST_WDATA = 3'h2;
	localparam logic [2:0] ST_RADDR = 3'h3;
	localparam logic [2:0] ST_RDATA = 3'h4;

	aldr_host_state_type s;
	aldr_host_state_type next_s;

	always_comb begin
		logic tick;
		logic reading;
		logic is_read;
		tick = (s.div == 16'(QUARTER - 1));
		reading = (s.step == ST_RDATA);
		is_read = s.cmd[aldr_pkg::HCMD_READ_BIT];
		next_s = s;
		next_s.rdata = 32'h0;

		// ==========================================================
		// command port
		if (rd) begin
			if (addr == aldr_pkg::HOST_REG_CMD) begin
				next_s.rdata = {12'h000, s.cmd};
			end else if (addr == aldr_pkg::HOST_REG_STATUS) begin
				next_s.rdata = {30'h0, s.nack, s.busy};
			end else if (addr == aldr_pkg::HOST_REG_DATA) begin
				next_s.rdata = s.data;
			end
		end
		if (wr && addr == aldr_pkg::HOST_REG_CMD && !s.busy) begin
			next_s.cmd = wdata[19:0];
			next_s.left = {1'b0, wdata[aldr_pkg::HCMD_COUNT_LSB +: 2]} + 3'h1;
			next_s.busy = 1'b1;
			next_s.nack = 1'b0;
			next_s.st = H_START;
			next_s.step = ST_WADDR;
			next_s.q = 2'h0;
			next_s.div = 16'h0;
		end

		// ==========================================================
		// bit engine, four quarters per bit
		if (s.st != H_IDLE) begin
			next_s.div = tick ? 16'h0 : s.div + 16'h1;
		end
		if (s.st != H_IDLE && tick) begin
			next_s.q = s.q + 2'h1;
			case (s.st)
				H_START: begin
					case (s.q)
						2'h0: next_s.sda_rel = 1'b1;
						2'h1: next_s.scl = 1'b1;
						2'h2: next_s.sda_rel = 1'b0;
						default: begin
							next_s.scl = 1'b0;
							next_s.st = H_BYTE;
							next_s.bitn = 4'h0;
							next_s.sh = (s.step == ST_WADDR) ? aldr_pkg::ADDR_BYTE_WRITE : aldr_pkg::ADDR_BYTE_READ;
						end
					endcase
				end
				H_BYTE: begin
					case (s.q)
						2'h0: begin
							if (s.bitn < 4'h8) begin
								next_s.sda_rel = reading ? 1'b1 : s.sh[7];
							end else begin
								next_s.sda_rel = reading ? (s.left == 3'h1) : 1'b1;
							end
						end
						2'h1: next_s.scl = 1'b1;
						2'h2: begin
							if (s.bitn < 4'h8) begin
								next_s.sh = {s.sh[6:0], bus.sda};
							end else if (!reading && bus.sda) begin
								next_s.nack = 1'b1;
							end
						end
						default: begin
							next_s.scl = 1'b0;
							next_s.bitn = s.bitn + 4'h1;
							if (s.bitn == 4'h8) begin
								next_s.bitn = 4'h0;
								if (s.nack) begin
									next_s.st = H_STOP;
								end else begin
									case (s.step)
										ST_WADDR: begin
											next_s.step = ST_PTR;
											next_s.sh = s.cmd[7:0];
										end
										ST_PTR: begin
											if (!is_read) begin
												next_s.step = ST_WDATA;
												next_s.sh = s.cmd[15:8];
											end else if (s.cmd[aldr_pkg::HCMD_RSTART_BIT]) begin
												next_s.step = ST_RADDR;
												next_s.st = H_START;
											end else begin
												next_s.st = H_STOP;
											end
										end
										ST_RADDR: next_s.step = ST_RDATA;
										ST_RDATA: begin
											next_s.data = {s.data[23:0], s.sh};
											next_s.left = s.left - 3'h1;
											if (s.left == 3'h1) begin
												next_s.st = H_STOP;
											end
										end
										default: next_s.st = H_STOP;
									endcase
								end
							end
						end
					endcase
				end
				default: begin
					case (s.q)
						2'h0: next_s.sda_rel = 1'b0;
						2'h1: next_s.scl = 1'b1;
						2'h2: next_s.sda_rel = 1'b1;
						default: begin
							if (s.step == ST_PTR && is_read && !s.nack) begin
								next_s.step = ST_RADDR;
								next_s.st = H_START;
							end else begin
								next_s.st = H_IDLE;
								next_s.busy = 1'b0;
							end
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
			s.scl <= 1'b1;
			s.sda_rel <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign bus.scl = s.scl;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = s.sda_rel;
	assign rdata = s.rdata;
endmodule : aldr_host

/* File: verif/aldr_link_asserts.sv */
/*
 * Checker of the two-wire link between controller and sensor end.
 * Assumes scl and sda are sampled on the one system clock.
 */
`timescale 1ns/10ps
module aldr_link_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	// ==========================================================
	// bit tracking
	logic scl_d;
	logic sda_d;
	logic first;
	logic [3:0] nbit;
	logic [7:0] sda_byte;
	wire start = scl && scl_d && sda_d && !sda;
	wire rise = scl && !scl_d;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scl_d <= 1'h1;
			sda_d <= 1'h1;
			first <= 1'h0;
			nbit <= 4'h0;
			sda_byte <= 8'h00;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (start) begin
				first <= 1'h1;
				nbit <= 4'h0;
			end else if (rise) begin
				sda_byte <= {sda_byte[6:0], sda};
				nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
				first <= first && (nbit != 4'h8);
			end
		end
	end

	// ==========================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence stop_seq;
		scl && $past(scl) && sda && !$past(sda);
	endsequence
	sequence addr_slot;
		rise && first && nbit == 4'h8;
	endsequence

	reset_idle_a: assert property ($rose(reset_n) |-> scl && host_sda_oe_n && dev_sda_oe_n)
		else $error("link not released after reset");
	open_drain_a: assert property ((host_sda_oe_n || !host_sda_o) && (dev_sda_oe_n || !dev_sda_o))
		else $error("data line driven high");
	addr_byte_a: assert property (addr_slot |-> sda_byte[7:1] == aldr_pkg::SLAVE_ADDR)
		else $error("wrong slave address");
	addr_ack_a: assert property (addr_slot |-> !dev_sda_oe_n && !sda)
		else $error("address not acknowledged");
	addr_quiet_a: assert property (first && nbit < 4'h8 && scl |-> dev_sda_oe_n)
		else $error("sensor drives during address");
	hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("sensor data changed while clock high");
	scl_high_a: assert property ($rose(scl) |-> scl[*4])
		else $error("clock high phase too short");
	stop_idle_a: assert property (stop_seq |=> (scl && sda && dev_sda_oe_n)[*3])
		else $error("bus not idle after stop");
endmodule : aldr_link_asserts

/* File: verif/ambient_light_i2c_readout_bench.sv */
/*
 * Bench joining controller and sensor end over the link.
 * Assumes shortened conversion, frame and bit counts.
 */
`timescale 1ns/10ps
module ambient_light_i2c_readout_bench;
	localparam int CONV = 20;
	localparam int FRAME = 3000;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [31:0] rdata;
	logic [15:0] light_sample = 16'h0000;
	logic standby;
	logic [15:0] ambient_result;
	logic [7:0] mode_tab [5] = '{8'h01, 8'h03, 8'h07, 8'h83, 8'h87};
	int num_errors = 0;
	int checks = 0;

	aldr_i2c_if aldr_i2c_if_i ();
	aldr_host #(.QUARTER(4)) aldr_host_i (.clk(clk), .reset_n(reset_n), .bus(aldr_i2c_if_i),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	aldr_sensor #(.CONV_CYC(CONV), .FRAME_CYC(FRAME)) aldr_sensor_i (.clk(clk), .reset_n(reset_n),
		.bus(aldr_i2c_if_i), .light_sample(light_sample), .standby(standby), .ambient_result(ambient_result));
	aldr_link_asserts aldr_link_asserts_i (.clk(clk), .reset_n(reset_n), .scl(aldr_i2c_if_i.scl),
		.host_sda_o(aldr_i2c_if_i.host_sda_o), .host_sda_oe_n(aldr_i2c_if_i.host_sda_oe_n),
		.dev_sda_o(aldr_i2c_if_i.dev_sda_o), .dev_sda_oe_n(aldr_i2c_if_i.dev_sda_oe_n), .sda(aldr_i2c_if_i.sda));

	always #2 clk = ~clk;

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask : reg_rd

	task automatic xfer(input logic [19:0] cmd);
		logic [31:0] s;
		reg_wr(aldr_pkg::HOST_REG_CMD, {12'h000, cmd});
		s = 32'h1;
		for (int i = 0; i < 3000 && s[0] !== 1'h0; i++) begin
			reg_rd(aldr_pkg::HOST_REG_STATUS, s);
		end
		check("status", s[1:0], 2'h0);
	endtask : xfer

	task automatic dev_rd(input logic [7:0] ptr, input logic [1:0] n, input logic rs, output logic [31:0] d);
		xfer({n, rs, 1'h1, 8'h00, ptr});
		reg_rd(aldr_pkg::HOST_REG_DATA, d);
	endtask : dev_rd

	task automatic dev_wr(input logic [7:0] ptr, input logic [7:0] v);
		xfer({2'h0, 1'h0, 1'h0, v, ptr});
	endtask : dev_wr

	// ==========================================================
	// tests
	initial begin
		logic [31:0] d;
		logic [15:0] smp;
		logic [7:0] mode;
		int lat;
		int n;
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		repeat (8) @(posedge clk);
		check("standby_reset", standby, 1'h1);
		dev_rd(aldr_pkg::REG_MODULATOR_TIMING, 2'h1, 1'h0, d);
		check("mod_rsvd", d[15:0], 16'h0100);
		dev_wr(aldr_pkg::REG_MODULATOR_TIMING, 8'h5a);
		dev_wr(aldr_pkg::REG_AMBIENT_INFRARED_LEVEL, 8'hff);
		dev_rd(aldr_pkg::REG_MODULATOR_TIMING, 2'h1, 1'h1, d);
		check("mod_rw", d[15:0], 16'h5a00);
		dev_wr(aldr_pkg::REG_MODULATOR_TIMING, 8'h01);
		reg_rd(8'h0c, d);
		check("unmapped", d, 32'h0);
		for (int k = 0; k < 5; k++) begin
			mode = mode_tab[k];
			lat = mode[7] ? (1 << mode[2:0]) * CONV : FRAME;
			smp = 16'h1357 + 16'(k) * 16'h1111;
			@(posedge clk);
			light_sample <= smp;
			dev_wr(aldr_pkg::REG_AMBIENT_PARAM, mode);
			dev_wr(aldr_pkg::REG_COMMAND, 8'h10);
			check("standby_run", standby, 1'h0);
			n = 0;
			while (ambient_result !== smp && n < FRAME + 500) begin
				@(posedge clk);
				#1 n++;
			end
			check("latency", 32'(n >= lat - 80 && n <= lat + 10), 32'h1);
			repeat (2) @(posedge clk);
			#1 check("standby_done", standby, 1'h1);
			check("result_port", ambient_result, smp);
			dev_rd(aldr_pkg::REG_COMMAND, 2'h0, k[0], d);
			check("ready_set", d[7:0], 8'h40);
			dev_rd(aldr_pkg::REG_AMBIENT_RESULT_HIGH, 2'h1, k[0], d);
			check("result_bus", d[15:0], smp);
			dev_rd(aldr_pkg::REG_COMMAND, 2'h0, 1'h0, d);
			check("ready_clear", d[7:0], 8'h00);
		end
		dev_wr(aldr_pkg::REG_AMBIENT_PARAM, 8'h81);
		@(posedge clk);
		light_sample <= 16'h2468;
		dev_wr(aldr_pkg::REG_COMMAND, 8'h04);
		n = 0;
		while (ambient_result !== 16'h2468 && n < 500) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		light_sample <= 16'h0bcd;
		n = 0;
		while (ambient_result !== 16'h0bcd && n < 500) begin
			@(posedge clk);
			#1 n++;
		end
		check("periodic_gap", 32'(n >= 2 * CONV - 4 && n <= 2 * CONV), 32'h1);
		check("standby_periodic", standby, 1'h0);
		dev_wr(aldr_pkg::REG_COMMAND, 8'h00);
		repeat (3 * CONV) @(posedge clk);
		#1 check("standby_stop", standby, 1'h1);
		conclude();
	end

	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		conclude();
	end
endmodule : ambient_light_i2c_readout_bench
